// ### design/flash_cmd_pkg.sv
// Shared constants and types of the serial flash write-command unit.
// Assumes a 250 MHz system clock; all link pins are sampled by that clock.
`default_nettype none
package flash_cmd_pkg;

	// ----------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_BYTE_PROGRAM  = 8'h02;
	localparam logic [7:0] OPC_AUTO_INC      = 8'haf;
	localparam logic [7:0] OPC_SECTOR_ERASE  = 8'h20;
	localparam logic [7:0] OPC_BLOCK_ERASE   = 8'h52;
	localparam logic [7:0] OPC_CHIP_ERASE    = 8'h60;
	localparam logic [7:0] OPC_STATUS_READ   = 8'h05;
	localparam logic [7:0] OPC_WRITE_ENABLE  = 8'h06;
	localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OPC_STATUS_ARM    = 8'h50;
	localparam logic [7:0] OPC_STATUS_WRITE  = 8'h01;

	// ----------------------------------------------------------------
	// Address layout and protection map
	// ----------------------------------------------------------------
	localparam int          TOP_ADDRESS_BIT   = 17;
	localparam int          ADDR_W            = TOP_ADDRESS_BIT + 1;
	localparam int          SECTOR_SELECT_LOW = 12;
	localparam int          BLOCK_SELECT_LOW  = 15;
	localparam logic [1:0]  ADDR_LAST_BYTE    = 2'h2;
	localparam logic [18:0] PROTECT_BASE_NONE = 19'h40000;
	localparam logic [18:0] PROTECT_BASE_L1   = 19'h30000;
	localparam logic [18:0] PROTECT_BASE_L2   = 19'h20000;
	localparam logic [18:0] PROTECT_BASE_L3   = 19'h00000;

	// ----------------------------------------------------------------
	// Status byte fields and reset values
	// ----------------------------------------------------------------
	localparam int         STAT_BUSY_BIT       = 0;
	localparam int         STAT_LATCH_BIT      = 1;
	localparam int         STAT_LEVEL_LOW_BIT  = 2;
	localparam int         STAT_LEVEL_HIGH_BIT = 3;
	localparam int         STAT_AUTO_INC_BIT   = 6;
	localparam int         STAT_LOCK_BIT       = 7;
	localparam logic [1:0] PROTECT_LEVEL_RESET = 2'h0;
	localparam logic       LOCKDOWN_RESET      = 1'b0;
	// Idle levels of clock, select, protect and data, so no false edge follows reset
	localparam logic [3:0] PIN_SYNC_RESET      = 4'hf;

	// ----------------------------------------------------------------
	// Self-timed operation durations
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ                 = 250;
	localparam int unsigned BYTE_PROGRAM_TIME_US    = 20;
	localparam int unsigned SECTOR_ERASE_TIME_US    = 25000;
	localparam int unsigned BLOCK_ERASE_TIME_US     = 25000;
	localparam int unsigned CHIP_ERASE_TIME_US      = 100000;
	localparam int unsigned BYTE_PROGRAM_CYCLES_DEF = BYTE_PROGRAM_TIME_US * CLK_MHZ;
	localparam int unsigned SECTOR_ERASE_CYCLES_DEF = SECTOR_ERASE_TIME_US * CLK_MHZ;
	localparam int unsigned BLOCK_ERASE_CYCLES_DEF  = BLOCK_ERASE_TIME_US * CLK_MHZ;
	localparam int unsigned CHIP_ERASE_CYCLES_DEF   = CHIP_ERASE_TIME_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		SEQ_IDLE   = 6'b000001,
		SEQ_OPCODE = 6'b000010,
		SEQ_ADDR   = 6'b000100,
		SEQ_DATA   = 6'b001000,
		SEQ_STATUS = 6'b010000,
		SEQ_SKIP   = 6'b100000
	} seq_state_t;

	typedef enum logic [1:0] {
		OP_BYTE   = 2'h0,
		OP_SECTOR = 2'h1,
		OP_BLOCK  = 2'h2,
		OP_CHIP   = 2'h3
	} array_op_t;

endpackage
`default_nettype wire

// ### design/flash_pin_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pins.
// Assumes each bit is an independent level; no bundle coherency.
`timescale 1ns/100ps
`default_nettype none
module flash_pin_sync #(
	parameter int               WIDTH       = 4,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sync_t;

	sync_t r_reg;
	sync_t r_next;

	// First stage feeds only the second stage
	always_comb begin
		r_next    = r_reg;
		r_next.s1 = d;
		r_next.s2 = r_reg.s1;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			r_reg <= {RESET_VALUE, RESET_VALUE};
		end else begin
			r_reg <= r_next;
		end
	end

	assign q = r_reg.s2;

endmodule
`default_nettype wire

// ### design/flash_op_timer.sv
// Self-timed duration counter for program and erase operations.
// Assumes start is a one-cycle pulse given only while not busy.
`timescale 1ns/100ps
`default_nettype none
module flash_op_timer (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        start,
	input  wire logic [31:0] cycles,
	output logic             busy,
	output logic             done
);

	typedef struct packed {
		logic        busy;
		logic        done;
		logic [31:0] count;
	} timer_t;

	timer_t r_reg;
	timer_t r_next;

	// Busy for exactly 'cycles' clocks, then a one-cycle done pulse
	always_comb begin
		r_next      = r_reg;
		r_next.done = 1'b0;
		if (start && !r_reg.busy) begin
			r_next.busy  = 1'b1;
			r_next.count = (cycles == 32'h0) ? 32'h0 : cycles - 32'h1;
		end else if (r_reg.busy) begin
			if (r_reg.count == 32'h0) begin
				r_next.busy = 1'b0;
				r_next.done = 1'b1;
			end else begin
				r_next.count = r_reg.count - 32'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign busy = r_reg.busy;
	assign done = r_reg.done;

endmodule
`default_nettype wire

// ### design/flash_write_cmd_unit.sv
// Command decoder and write control of a small serial flash (SPI mode 0/3 slave).
// Assumes the link pins are asynchronous to CLK_SYS and the link clock is far slower.
//
// Summary of operation
// - Byte program: opcode 02h, 24-bit address, one data byte, MSB first.
// - Byte program, sector or block erase into protected area is dropped.
// - Write enable sets the latch; program and erase need the latch set.
// - Select held low for the sequence; execution starts at its rising edge.
// - Program and erase are self-timed; busy bit shows progress.
// - Auto-increment: AFh, address, data; then AFh plus data at next address.
// - Host waits per byte, ends auto-increment with 04h, then polls status.
// - Auto-increment never wraps; after top unprotected byte, mode and latch clear.
// - Auto-increment starting in a protected area is ignored.
// - Opcode 20h erases the 4 KByte sector chosen by address bits 17..12.
// - Opcode 52h erases the 32 KByte block chosen by address bits 17..15.
// - Opcode 60h erases everything, ignored if any protection is set.
// - Status read accepted at any time, even while busy.
// - Status byte repeats on continuing clocks until select rises.
// - Write disable clears the latch and the auto-increment mode.
// - Status-write arm works only if status write is the very next command.
// - Armed status write changes only both level bits and lock-down bit.
// - Status write ignored when protect pin low and lock-down set.
// - Pin low: lock-down only goes 0 to 1; pin high: all three writable.
// - Pin and lock-down judged at select rise; one write may set all three.
// - Decode 06h, 04h, 05h, 50h, and 01h with one data byte.
// - Every opcode, address byte and data byte spans eight clocks.
`timescale 1ns/100ps
`default_nettype none
module flash_write_cmd_unit
	import flash_cmd_pkg::*;
#(
	parameter int unsigned BYTE_PROGRAM_CYCLES = flash_cmd_pkg::BYTE_PROGRAM_CYCLES_DEF,
	parameter int unsigned SECTOR_ERASE_CYCLES = flash_cmd_pkg::SECTOR_ERASE_CYCLES_DEF,
	parameter int unsigned BLOCK_ERASE_CYCLES  = flash_cmd_pkg::BLOCK_ERASE_CYCLES_DEF,
	parameter int unsigned CHIP_ERASE_CYCLES   = flash_cmd_pkg::CHIP_ERASE_CYCLES_DEF
) (
	input  wire logic                      CLK_SYS,
	input  wire logic                      RESET_N,
	input  wire logic                      SERIAL_CLK,
	input  wire logic                      CHIP_SELECT_N,
	input  wire logic                      SERIAL_IN,
	input  wire logic                      WRITE_PROTECT_N,
	output logic                           SERIAL_OUT,
	output logic                           SERIAL_OUT_OE_N,
	output logic                           ARRAY_START,
	output var flash_cmd_pkg::array_op_t   ARRAY_OP,
	output logic [flash_cmd_pkg::ADDR_W-1:0] ARRAY_ADDR,
	output logic [7:0]                     ARRAY_DATA,
	output logic                           BUSY,
	output logic                           WRITE_ENABLE_LATCH,
	output logic                           AUTO_INCREMENT_ACTIVE,
	output logic [1:0]                     PROTECT_LEVEL,
	output logic                           PROTECT_LOCKDOWN
);

	import flash_cmd_pkg::*;

	// ----------------------------------------------------------------
	// State record
	// ----------------------------------------------------------------
	typedef struct packed {
		seq_state_t        state;
		logic              sck_q;
		logic              ce_q;
		logic [7:0]        shift;
		logic [2:0]        bit_cnt;
		logic [1:0]        byte_cnt;
		logic [7:0]        opcode;
		logic [23:0]       addr;
		logic [7:0]        data;
		logic              cmd_ok;
		logic [2:0]        out_idx;
		logic              so;
		logic              so_oe_n;
		logic              we_latch;
		logic              auto_inc;
		logic [ADDR_W-1:0] auto_inc_addr;
		logic              arm;
		logic [1:0]        bp;
		logic              lock;
		logic              start;
		array_op_t         op;
		logic [ADDR_W-1:0] op_addr;
		logic [7:0]        op_data;
		logic [31:0]       op_cycles;
	} unit_t;

	unit_t r_reg;
	unit_t r_next;

	logic [3:0] pins_sync;
	logic       sck_s;
	logic       ce_s;
	logic       si_s;
	logic       wp_s;
	logic       busy;
	logic       op_done;
	logic       sck_rise;
	logic       sck_fall;
	logic       ce_fall;
	logic       ce_rise;
	logic [7:0] in_byte;
	logic [ADDR_W-1:0] cmd_addr;
	logic [7:0] status_now;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Lowest protected address; protected areas grow down from the top
	function automatic logic [18:0] protect_base(input logic [1:0] level);
		case (level)
			2'h1:    protect_base = PROTECT_BASE_L1;
			2'h2:    protect_base = PROTECT_BASE_L2;
			2'h3:    protect_base = PROTECT_BASE_L3;
			default: protect_base = PROTECT_BASE_NONE;
		endcase
	endfunction

	function automatic logic is_protected(input logic [ADDR_W-1:0] a, input logic [1:0] level);
		is_protected = ({1'b0, a} >= protect_base(level));
	endfunction

	function automatic logic [7:0] status_byte(input unit_t s, input logic b);
		status_byte                      = 8'h00;
		status_byte[STAT_BUSY_BIT]       = b;
		status_byte[STAT_LATCH_BIT]      = s.we_latch;
		status_byte[STAT_LEVEL_LOW_BIT]  = s.bp[0];
		status_byte[STAT_LEVEL_HIGH_BIT] = s.bp[1];
		status_byte[STAT_AUTO_INC_BIT]   = s.auto_inc;
		status_byte[STAT_LOCK_BIT]       = s.lock;
	endfunction

	function automatic logic [31:0] cycles_of(input array_op_t op);
		case (op)
			OP_SECTOR: cycles_of = SECTOR_ERASE_CYCLES;
			OP_BLOCK:  cycles_of = BLOCK_ERASE_CYCLES;
			OP_CHIP:   cycles_of = CHIP_ERASE_CYCLES;
			default:   cycles_of = BYTE_PROGRAM_CYCLES;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Pin sampling and edge detection
	// ----------------------------------------------------------------
	// sample link pins
	flash_pin_sync #(
		.WIDTH       (4),
		.RESET_VALUE (PIN_SYNC_RESET)
	) u_pin_sync (
		.clk     (CLK_SYS),
		.reset_n (RESET_N),
		.d       ({SERIAL_CLK, CHIP_SELECT_N, WRITE_PROTECT_N, SERIAL_IN}),
		.q       (pins_sync)
	);

	assign sck_s = pins_sync[3];
	assign ce_s  = pins_sync[2];
	assign wp_s  = pins_sync[1];
	assign si_s  = pins_sync[0];

	// Edges are taken from the synchronised copy and one more flop
	assign sck_rise = sck_s & ~r_reg.sck_q;
	assign sck_fall = ~sck_s & r_reg.sck_q;
	assign ce_fall  = ~ce_s & r_reg.ce_q;
	assign ce_rise  = ce_s & ~r_reg.ce_q;
	assign in_byte  = {r_reg.shift[6:0], si_s};
	assign cmd_addr = r_reg.addr[ADDR_W-1:0];
	// Live status, so busy is seen bit by bit
	assign status_now = status_byte(r_reg, busy);

	// ----------------------------------------------------------------
	// Self-timed operation timer
	// ----------------------------------------------------------------
	// busy tracks internal operation
	flash_op_timer u_op_timer (
		.clk     (CLK_SYS),
		.reset_n (RESET_N),
		.start   (r_reg.start),
		.cycles  (r_reg.op_cycles),
		.busy    (busy),
		.done    (op_done)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		r_next       = r_reg;
		r_next.start = 1'b0;
		r_next.sck_q = sck_s;
		r_next.ce_q  = ce_s;

		// latch clears at operation end, outside auto-increment or after its top byte
		// Handled first so a write enable in the same cycle wins
		if (op_done) begin
			if (!r_reg.auto_inc) begin
				r_next.we_latch = 1'b0;
			end else if ({1'b0, r_reg.auto_inc_addr} == protect_base(r_reg.bp) - 19'h1) begin
				r_next.auto_inc = 1'b0;
				r_next.we_latch = 1'b0;
			end
		end

		if (ce_fall) begin
			// New frame: clear byte framing
			r_next.state    = SEQ_OPCODE;
			r_next.bit_cnt  = 3'h0;
			r_next.byte_cnt = 2'h0;
			r_next.cmd_ok   = 1'b0;
		end else if (ce_rise) begin
			r_next.state   = SEQ_IDLE;
			r_next.so_oe_n = 1'b1;
			r_next.cmd_ok  = 1'b0;
			if (r_reg.state != SEQ_OPCODE && r_reg.state != SEQ_IDLE) begin
				r_next.arm = r_reg.cmd_ok && !busy && r_reg.opcode == OPC_STATUS_ARM;
			end
			// only status read is served while busy
			if (r_reg.cmd_ok && !busy) begin
				case (r_reg.opcode)
					OPC_WRITE_ENABLE: begin
						r_next.we_latch = 1'b1;
					end
					OPC_WRITE_DISABLE: begin
						r_next.we_latch = 1'b0;
						r_next.auto_inc = 1'b0;
					end
					OPC_STATUS_WRITE: begin
						if (r_reg.arm && (wp_s || !r_reg.lock)) begin
							r_next.bp   = {r_reg.data[STAT_LEVEL_HIGH_BIT], r_reg.data[STAT_LEVEL_LOW_BIT]};
							r_next.lock = r_reg.data[STAT_LOCK_BIT];
						end
					end
					OPC_BYTE_PROGRAM: begin
						if (r_reg.we_latch && !is_protected(cmd_addr, r_reg.bp)) begin
							r_next.start   = 1'b1;
							r_next.op      = OP_BYTE;
							r_next.op_addr = cmd_addr;
							r_next.op_data = r_reg.data;
						end
					end
					OPC_SECTOR_ERASE: begin
						if (r_reg.we_latch && !is_protected(cmd_addr, r_reg.bp)) begin
							r_next.start   = 1'b1;
							r_next.op      = OP_SECTOR;
							r_next.op_addr = {cmd_addr[ADDR_W-1:SECTOR_SELECT_LOW], 12'h000};
							r_next.op_data = 8'hff;
						end
					end
					OPC_BLOCK_ERASE: begin
						if (r_reg.we_latch && !is_protected(cmd_addr, r_reg.bp)) begin
							r_next.start   = 1'b1;
							r_next.op      = OP_BLOCK;
							r_next.op_addr = {cmd_addr[ADDR_W-1:BLOCK_SELECT_LOW], 15'h0000};
							r_next.op_data = 8'hff;
						end
					end
					OPC_CHIP_ERASE: begin
						if (r_reg.we_latch && r_reg.bp == 2'h0) begin
							r_next.start   = 1'b1;
							r_next.op      = OP_CHIP;
							r_next.op_addr = '0;
							r_next.op_data = 8'hff;
						end
					end
					OPC_AUTO_INC: begin
						// next address; dropped when the top byte ends this cycle
						if (r_next.we_latch && r_next.auto_inc) begin
							r_next.start         = 1'b1;
							r_next.op            = OP_BYTE;
							r_next.op_addr       = r_reg.auto_inc_addr + 18'h1;
							r_next.auto_inc_addr = r_reg.auto_inc_addr + 18'h1;
							r_next.op_data       = r_reg.data;
						end else if (!r_reg.auto_inc && r_reg.we_latch && !is_protected(cmd_addr, r_reg.bp)) begin
							r_next.auto_inc      = 1'b1;
							r_next.start         = 1'b1;
							r_next.op            = OP_BYTE;
							r_next.op_addr       = cmd_addr;
							r_next.auto_inc_addr = cmd_addr;
							r_next.op_data       = r_reg.data;
						end
					end
					default: begin
						r_next.cmd_ok = 1'b0;
					end
				endcase
			end
		end else if (!ce_s && sck_rise && r_reg.state != SEQ_IDLE) begin
			r_next.shift   = in_byte;
			r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
			if (r_reg.bit_cnt == 3'h7) begin
				case (r_reg.state)
					SEQ_OPCODE: begin
						r_next.opcode = in_byte;
						case (in_byte)
							OPC_BYTE_PROGRAM, OPC_SECTOR_ERASE, OPC_BLOCK_ERASE: begin
								r_next.state = SEQ_ADDR;
							end
							OPC_AUTO_INC: begin
								// address only on the first byte
								r_next.state = r_reg.auto_inc ? SEQ_DATA : SEQ_ADDR;
							end
							OPC_STATUS_WRITE: begin
								r_next.state = SEQ_DATA;
							end
							OPC_STATUS_READ: begin
								r_next.state   = SEQ_STATUS;
								r_next.out_idx = 3'h0;
								r_next.cmd_ok  = 1'b1;
							end
							default: begin
								r_next.state  = SEQ_SKIP;
								r_next.cmd_ok = 1'b1;
							end
						endcase
					end
					SEQ_ADDR: begin
						r_next.addr     = {r_reg.addr[15:0], in_byte};
						r_next.byte_cnt = r_reg.byte_cnt + 2'h1;
						if (r_reg.byte_cnt == ADDR_LAST_BYTE) begin
							if (r_reg.opcode == OPC_BYTE_PROGRAM || r_reg.opcode == OPC_AUTO_INC) begin
								r_next.state = SEQ_DATA;
							end else begin
								r_next.state  = SEQ_SKIP;
								r_next.cmd_ok = 1'b1;
							end
						end
					end
					SEQ_DATA: begin
						r_next.data   = in_byte;
						r_next.state  = SEQ_SKIP;
						r_next.cmd_ok = 1'b1;
					end
					default: begin
						r_next.state = r_reg.state;
					end
				endcase
			end
		end else if (!ce_s && sck_fall && r_reg.state == SEQ_STATUS) begin
			// status repeats, shifted on falling edge
			r_next.so      = status_now[3'h7 - r_reg.out_idx];
			r_next.so_oe_n = 1'b0;
			r_next.out_idx = r_reg.out_idx + 3'h1;
		end

		// Start one cycle later than decision; fill its duration
		r_next.op_cycles = cycles_of(r_next.op);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			r_reg          <= '0;
			r_reg.state    <= SEQ_IDLE;
			r_reg.sck_q    <= 1'b1;
			r_reg.ce_q     <= 1'b1;
			r_reg.so_oe_n  <= 1'b1;
			r_reg.bp       <= PROTECT_LEVEL_RESET;
			r_reg.lock     <= LOCKDOWN_RESET;
			r_reg.op       <= OP_BYTE;
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign SERIAL_OUT            = r_reg.so;
	assign SERIAL_OUT_OE_N       = r_reg.so_oe_n;
	assign ARRAY_START           = r_reg.start;
	assign ARRAY_OP              = r_reg.op;
	assign ARRAY_ADDR            = r_reg.op_addr;
	assign ARRAY_DATA            = r_reg.op_data;
	assign BUSY                  = busy;
	assign WRITE_ENABLE_LATCH    = r_reg.we_latch;
	assign AUTO_INCREMENT_ACTIVE = r_reg.auto_inc;
	assign PROTECT_LEVEL         = r_reg.bp;
	assign PROTECT_LOCKDOWN      = r_reg.lock;

endmodule
`default_nettype wire

// ### sim/flash_write_cmd_properties.sv
// Concurrent checks on the ports of the flash write-command unit.
// Assumes the bind below hands on the unit's own timing parameters.
`timescale 1ns/100ps
`default_nettype none
module flash_write_cmd_checker
	import flash_cmd_pkg::*;
#(
	parameter int unsigned BYTE_PROGRAM_CYCLES = 20,
	parameter int unsigned SECTOR_ERASE_CYCLES = 40,
	parameter int unsigned BLOCK_ERASE_CYCLES  = 40,
	parameter int unsigned CHIP_ERASE_CYCLES   = 60
) (
	input wire logic              CLK_SYS,
	input wire logic              RESET_N,
	input wire logic              CHIP_SELECT_N,
	input wire logic              WRITE_PROTECT_N,
	input wire logic              SERIAL_OUT_OE_N,
	input wire logic              ARRAY_START,
	input wire array_op_t         ARRAY_OP,
	input wire logic [ADDR_W-1:0] ARRAY_ADDR,
	input wire logic [7:0]        ARRAY_DATA,
	input wire logic              BUSY,
	input wire logic              WRITE_ENABLE_LATCH,
	input wire logic              AUTO_INCREMENT_ACTIVE,
	input wire logic [1:0]        PROTECT_LEVEL,
	input wire logic              PROTECT_LOCKDOWN
);
	logic [31:0] run_cnt;
	logic [31:0] run_len;
	logic [2:0]  wp_low;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	// Busy length per launch kind; pin low time saturates so it never wraps
	always_ff @(posedge CLK_SYS) begin
		run_cnt <= (!RESET_N || ARRAY_START) ? 32'h0 : run_cnt + {31'h0, BUSY};
		if (ARRAY_START)
			run_len <= ARRAY_OP == OP_BYTE ? BYTE_PROGRAM_CYCLES : ARRAY_OP == OP_SECTOR ? SECTOR_ERASE_CYCLES
				: ARRAY_OP == OP_BLOCK ? BLOCK_ERASE_CYCLES : CHIP_ERASE_CYCLES;
		wp_low <= (!RESET_N || WRITE_PROTECT_N) ? 3'h0 : wp_low + {2'h0, wp_low != 3'h7};
	end
	a_busy_follows: assert property (ARRAY_START |=> BUSY)
		else $error("busy missing after launch");
	a_busy_length: assert property ($fell(BUSY) |-> run_cnt == run_len)
		else $error("busy length wrong");
	a_launch_gate: assert property (ARRAY_START |-> WRITE_ENABLE_LATCH && !BUSY && CHIP_SELECT_N)
		else $error("launch not allowed here");
	a_erase_shape: assert property (ARRAY_START && ARRAY_OP != OP_BYTE |-> ARRAY_DATA == 8'hff &&
		(ARRAY_OP == OP_SECTOR ? ARRAY_ADDR[11:0] == 12'h0 : ARRAY_OP == OP_BLOCK ? ARRAY_ADDR[14:0] == 15'h0
		: ARRAY_ADDR == 18'h0 && PROTECT_LEVEL == 2'h0)) else $error("erase target wrong");
	a_target_free: assert property (ARRAY_START && ARRAY_OP != OP_CHIP |-> PROTECT_LEVEL == 2'h0 ||
		PROTECT_LEVEL == 2'h1 && ARRAY_ADDR < 18'h30000 || PROTECT_LEVEL == 2'h2 && !ARRAY_ADDR[17])
		else $error("launch into protected area");
	a_latch_drop: assert property ($fell(BUSY) && !AUTO_INCREMENT_ACTIVE |=> !WRITE_ENABLE_LATCH)
		else $error("latch kept after operation");
	a_lock_hold: assert property (wp_low == 3'h7 && $past(PROTECT_LOCKDOWN) |->
		$stable({PROTECT_LEVEL, PROTECT_LOCKDOWN})) else $error("locked status changed");
	a_out_release: assert property (CHIP_SELECT_N [*6] |-> SERIAL_OUT_OE_N)
		else $error("output driven while deselected");
endmodule
bind flash_write_cmd_unit flash_write_cmd_checker #(.BYTE_PROGRAM_CYCLES(BYTE_PROGRAM_CYCLES),
	.SECTOR_ERASE_CYCLES(SECTOR_ERASE_CYCLES), .BLOCK_ERASE_CYCLES(BLOCK_ERASE_CYCLES),
	.CHIP_ERASE_CYCLES(CHIP_ERASE_CYCLES)) i_flash_write_cmd_checker (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
	.CHIP_SELECT_N(CHIP_SELECT_N), .WRITE_PROTECT_N(WRITE_PROTECT_N), .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N),
	.ARRAY_START(ARRAY_START), .ARRAY_OP(ARRAY_OP), .ARRAY_ADDR(ARRAY_ADDR), .ARRAY_DATA(ARRAY_DATA),
	.BUSY(BUSY), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .AUTO_INCREMENT_ACTIVE(AUTO_INCREMENT_ACTIVE),
	.PROTECT_LEVEL(PROTECT_LEVEL), .PROTECT_LOCKDOWN(PROTECT_LOCKDOWN));
`default_nettype wire

// ### sim/spi_host_model.sv
// Behavioural mode 3 host driving the link pins of the flash unit.
// Assumes clk is the bench system clock; pins move on its falling edge.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
	input  wire logic clk,
	input  wire logic so,
	output logic      sck,
	output logic      cs_n,
	output logic      si
);
	// Idle link: clock parked high, select high
	initial begin
		sck = 1'b1;
		cs_n = 1'b1;
		si = 1'b1;
	end
	// whole bytes, MSB first, one select-low frame, 32 ns period
	task automatic frame(input int n, input logic [39:0] tx, output logic [7:0] rx);
		rx = 8'h00;
		@(negedge clk);
		cs_n = 1'b0;
		repeat (4) @(negedge clk);
		for (int i = 8 * n - 1; i >= 0; i--) begin
			sck = 1'b0;
			si = tx[i];
			repeat (4) @(negedge clk);
			sck = 1'b1;
			repeat (2) @(negedge clk);
			rx = {rx[6:0], so};
			repeat (2) @(negedge clk);
		end
		cs_n = 1'b1;
		// Released line flips, so a stale bit never reads as data
		si = ~si;
		repeat (8) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench of the flash write-command unit with a mode 3 host.
// Assumes the package, host model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
	$display("[FAIL] %0t got %h want %h", $time, (a), (e)); end end
module testbench;
	import flash_cmd_pkg::*;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic        wp_n = 1'b1;
	wire         sck, cs_n, si, so, oe_n, start, busy, we_latch, auto_inc, lock;
	wire [1:0]   level;
	wire [7:0]   data;
	wire [17:0]  addr;
	array_op_t   op;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          cyc = 0;
	logic [27:0] exp_q[$];
	logic [27:0] want;
	logic [23:0] a;
	logic [7:0]  d;
	// 250 MHz system clock
	initial forever #2 clk_sys = ~clk_sys;
	flash_write_cmd_unit #(.BYTE_PROGRAM_CYCLES(400), .SECTOR_ERASE_CYCLES(40), .BLOCK_ERASE_CYCLES(48),
		.CHIP_ERASE_CYCLES(60)) i_flash_write_cmd_unit (.CLK_SYS(clk_sys), .RESET_N(reset_n), .SERIAL_CLK(sck),
		.CHIP_SELECT_N(cs_n), .SERIAL_IN(si), .WRITE_PROTECT_N(wp_n), .SERIAL_OUT(so), .SERIAL_OUT_OE_N(oe_n),
		.ARRAY_START(start), .ARRAY_OP(op), .ARRAY_ADDR(addr), .ARRAY_DATA(data), .BUSY(busy),
		.WRITE_ENABLE_LATCH(we_latch), .AUTO_INCREMENT_ACTIVE(auto_inc), .PROTECT_LEVEL(level),
		.PROTECT_LOCKDOWN(lock));
	// Released data line reads inverted, so a stale bit never passes as status
	spi_host_model i_spi_host_model (.clk(clk_sys), .so(oe_n ? ~so : so), .sck(sck), .cs_n(cs_n), .si(si));
	task automatic cmd(input int n, input logic [39:0] tx);
		logic [7:0] r;
		i_spi_host_model.frame(n, tx, r);
	endtask
	// Status read; the second repeat is the one compared
	task automatic stat(input logic [7:0] e);
		logic [7:0] r;
		i_spi_host_model.frame(3, {8'h05, 16'h5aa5}, r);
		`CHK(r, e)
		`CHK(({lock, auto_inc, level, we_latch}), ({e[7:6], e[3:1]}))
	endtask
	// Write enable, then note the launch the next command should cause
	task automatic arm(input logic [27:0] e);
		cmd(1, 8'h06);
		exp_q.push_back(e);
	endtask
	task automatic swr(input logic [7:0] v);
		cmd(1, 8'h50);
		cmd(2, {8'h01, v});
	endtask
	// bounded wait for the self-timed operation
	task automatic idle;
		for (int k = 0; k < 500 && busy !== 1'b0; k++)
			@(negedge clk_sys);
		`CHK(busy, 1'b0)
	endtask
	task automatic results;
		if (error_cnt == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Every launch takes the oldest note; an unnoted launch fails
	always @(negedge clk_sys) begin
		if (start === 1'b1) begin
			want = '1;
			if (exp_q.size() > 0)
				want = exp_q.pop_front();
			`CHK(({op, addr, data}), want)
		end
	end
	// Hang guard, about five times the expected run
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			results;
		end
	end
	initial begin
		void'($urandom(32'hdd36));
		repeat (12) @(negedge clk_sys);
		reset_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		stat(8'h00);
		cmd(5, {8'h02, 24'h000100, 8'h5a});
		cmd(1, 8'h06);
		stat(8'h02);
		cmd(1, 8'h04);
		stat(8'h00);
		// each random target is programmed once only
		a = $urandom;
		d = $urandom;
		arm({OP_BYTE, a[17:0], d});
		cmd(5, {8'h02, a, d});
		stat(8'h03);
		idle;
		stat(8'h00);
		for (int k = 0; k < 3; k++) begin
			a = $urandom;
			if (k < 2) begin
				arm(k == 0 ? {OP_SECTOR, a[17:12], 12'h0, 8'hff} : {OP_BLOCK, a[17:15], 15'h0, 8'hff});
				cmd(4, {k == 0 ? 8'h20 : 8'h52, a});
			end else begin
				arm({OP_CHIP, 18'h0, 8'hff});
				cmd(1, 8'h60);
			end
			idle;
		end
		cmd(2, {8'h01, 8'h8c});
		stat(8'h00);
		swr(8'hff);
		stat(8'h8c);
		cmd(1, 8'h06);
		cmd(1, 8'h60);
		wp_n = 1'b0;
		swr(8'h00);
		stat(8'h8e);
		wp_n = 1'b1;
		swr(8'h04);
		stat(8'h06);
		wp_n = 1'b0;
		swr(8'h84);
		stat(8'h86);
		cmd(5, {8'haf, 24'h030000, 8'h33});
		arm({OP_BLOCK, 18'h28000, 8'hff});
		cmd(4, {8'h52, 24'h02ffff});
		idle;
		// Auto-increment up to the top unprotected byte, then no wrap
		d = $urandom;
		arm({OP_BYTE, 18'h2fffe, d});
		cmd(5, {8'haf, 24'h02fffe, d});
		idle;
		stat(8'hc6);
		exp_q.push_back({OP_BYTE, 18'h2ffff, ~d});
		cmd(2, {8'haf, ~d});
		idle;
		cmd(2, {8'haf, d});
		idle;
		stat(8'h84);
		`CHK(exp_q.size(), 0)
		results;
	end
endmodule
`default_nettype wire
